// ===== common/pipe_ctrl_regs.svh
/*
  timing counts and field layout for the pipeline control block.
  assumes inclusion by the design file only.
*/
`ifndef PIPE_CTRL_REGS_SVH
`define PIPE_CTRL_REGS_SVH
`define STAGE_COUNT 6
`define EXEC_UNIT_COUNT 6
`define MUL_STAGES 3
`define MUL_ITER_STAGE 2
`define FP_STAGES 3
`define FP_ITER_STAGE 1
`define DECODE_CORRECT_SLOTS 2
`define DIV_ITER_CYCLES 8'h10
`define FPDIV_ITER_CYCLES 8'h10
`define PAGE_LSB 12
`endif

// ===== common/pipe_ctrl_pkg.sv
/*
  types shared by the pipeline control block.
  assumes nothing beyond the constants header.
*/
package pipe_ctrl_pkg;
  typedef enum logic [2:0] {
    UNIT_INT = 3'h0,
    UNIT_MCI = 3'h1,
    UNIT_FP = 3'h2,
    UNIT_LSU = 3'h3,
    UNIT_BR = 3'h4,
    UNIT_CRL = 3'h5
  } unit_e;
  typedef enum logic [2:0] {
    MC_IDLE = 3'b001,
    MC_RUN = 3'b010,
    MC_ITER = 3'b100
  } mc_state_e;
endpackage

// ===== verilog/superscalar_pipeline_control.sv
/*
  control for a six-stage superscalar pipeline: fetch, decode, dispatch,
  execute, complete, writeback. tracks queues, reservation stations,
  reorder buffer, rename buffers, multicycle units and flush.
  assumes units report finish with the reorder tag they were given,
  and that one instruction at a time is offered per stage.
*/
`include "pipe_ctrl_regs.svh"

// Overview of operation
// - every instruction passes fetch, decode, dispatch, execute, complete, writeback
// - fetch fills decode queue from instruction cache and computes next address
// - time-critical decode on dispatch queue; rest deferred to dispatch
// - dispatch decides issue and latches into unit latch or reservation station
// - dispatch allocates rename and reorder buffer entries
// - six execution units, entry from dispatch or own reservation station
// - finishing unit writes rename entry and signals completion
// - unit reports internal exception and keeps executing
// - completed instructions retire from reorder buffer, may copy results early
// - exception or mispredict cancels younger, discards renames, redirects fetch
// - condition, count and link registers update at completion
// - writeback copies rename contents not already written at completion
// - integer multiplier three stages; divide iterates in stage two
// - special register moves run in multicycle unit alongside multiply/divide
// - floating pipeline three stages; divide iterates in first stage
// - at most one condition-logic or branch dispatch per clock
// - branch and condition logic run together; branches stay in order
// - either of those reservation stations full blocks both
// - decode correction for count/link targets only without pending update, first two slots
// - translation off: fetch only on hit or same page as last fetch
module superscalar_pipeline_control
  import pipe_ctrl_pkg::*;
#(
  parameter int ROB_DEPTH = 16,
  parameter int RENAME_DEPTH = 12,
  parameter int RS_DEPTH = 2,
  parameter int ADDR_W = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instrTranslateEnable,
  input wire logic icacheHit,
  input wire logic [ADDR_W-1:0] fetchAddr,
  input wire logic decodeQueueFull,
  input wire logic dispValid,
  input wire logic [2:0] dispUnit,
  input wire logic dispNeedsRename,
  input wire logic dispIsMul,
  input wire logic dispIsDiv,
  input wire logic dispIsSpr,
  input wire logic dispIsFpDiv,
  input wire logic dispIsFp,
  input wire logic dispWritesCtrLr,
  input wire logic dispWritesCond,
  input wire logic decodeBranchViaCtrLr,
  input wire logic [1:0] decodeSlot,
  input wire logic [RS_DEPTH:0] crlRsFree,
  input wire logic [RS_DEPTH:0] brRsFree,
  input wire logic finValid,
  input wire logic [3:0] finTag,
  input wire logic finExcept,
  input wire logic finMispredict,
  input wire logic [ADDR_W-1:0] finTarget,
  output logic fetchEnable,
  output logic [ADDR_W-1:0] nextFetchAddr,
  output logic decodeCorrect,
  output logic dispAccept,
  output logic [3:0] dispTag,
  output logic [3:0] dispRenameIdx,
  output logic retireValid,
  output logic [3:0] retireTag,
  output logic retireSprUpdate,
  output logic writebackValid,
  output logic [3:0] writebackRenameIdx,
  output logic flush,
  output logic [ADDR_W-1:0] redirectAddr,
  output logic mulBusy,
  output logic fpIterBusy,
  output logic [`STAGE_COUNT-1:0] stageActive
);
  localparam int TW = 4;
  logic [ROB_DEPTH-1:0] robValid_reg, robValid_next;
  logic [ROB_DEPTH-1:0] robDone_reg, robDone_next;
  logic [ROB_DEPTH-1:0] robExc_reg, robExc_next;
  logic [ROB_DEPTH-1:0] robMisp_reg, robMisp_next;
  logic [ROB_DEPTH-1:0] robSpr_reg, robSpr_next;
  logic [ROB_DEPTH-1:0] robRen_reg, robRen_next;
  logic [ADDR_W-1:0] robTgt_reg [ROB_DEPTH];
  logic [TW-1:0] robRenIdx_reg [ROB_DEPTH];
  logic [TW-1:0] head_reg, head_next, tail_reg, tail_next;
  logic [TW:0] robCount_reg, robCount_next;
  logic [TW:0] renCount_reg, renCount_next;
  logic [TW-1:0] renTail_reg, renTail_next;
  logic [TW-1:0] renHead_reg, renHead_next;
  logic ctrLrPending_reg, ctrLrPending_next;
  logic [ADDR_W-1:`PAGE_LSB] lastPage_reg, lastPage_next;
  logic lastPageValid_reg, lastPageValid_next;
  logic [ADDR_W-1:0] pc_reg, pc_next;
  logic [TW-1:0] wbIdx_reg, wbIdx_next;
  logic wbValid_reg, wbValid_next;
  logic retire_reg, retire_next;
  logic [TW-1:0] retTag_reg, retTag_next;
  logic retSpr_reg, retSpr_next;
  logic flush_reg, flush_next;
  logic [ADDR_W-1:0] redir_reg, redir_next;
  mc_state_e mcState_reg, mcState_next;
  logic [7:0] mcCnt_reg, mcCnt_next;
  logic [`MUL_STAGES-1:0] mulPipe_reg, mulPipe_next;
  logic [7:0] fpCnt_reg, fpCnt_next;
  logic [`FP_STAGES-1:0] fpPipe_reg, fpPipe_next;
  logic [`STAGE_COUNT-1:0] stage_reg, stage_next;

  logic samePage, robRoom, renRoom, unitFree, crBrBlock, isCrBr, doDisp;
  logic headDone, headBad;
  logic [TW-1:0] retRen;

  always_comb begin
    // fetch gating with translation off
    samePage = lastPageValid_reg && (fetchAddr[ADDR_W-1:`PAGE_LSB] == lastPage_reg);
    fetchEnable = !decodeQueueFull && !flush_reg &&
                  (instrTranslateEnable || icacheHit || samePage);
    nextFetchAddr = flush_reg ? redir_reg : pc_reg;
    decodeCorrect = decodeBranchViaCtrLr && !ctrLrPending_reg &&
                    (decodeSlot < 2'(`DECODE_CORRECT_SLOTS));
    robRoom = robCount_reg < (TW+1)'(ROB_DEPTH);
    renRoom = !dispNeedsRename || (renCount_reg < (TW+1)'(RENAME_DEPTH));
    isCrBr = (dispUnit == UNIT_BR) || (dispUnit == UNIT_CRL);
    crBrBlock = (crlRsFree == '0) || (brRsFree == '0);
    unitFree = 1'b1;
    // a divide holds the unit from its dispatch until its last iteration
    if (dispUnit == UNIT_MCI && (dispIsMul || dispIsDiv) && mcState_reg != MC_IDLE)
      unitFree = 1'b0;
    if (dispIsFp && fpCnt_reg != 8'h00)
      unitFree = 1'b0;
    // spr moves ignore the mul/div iteration
    // single dispatch port per clock keeps one cond-logic or branch issue
    doDisp = dispValid && robRoom && renRoom && unitFree && !flush_reg &&
             !(isCrBr && crBrBlock);
    dispAccept = doDisp;
    dispTag = tail_reg;
    dispRenameIdx = renTail_reg;
    headDone = robValid_reg[head_reg] && robDone_reg[head_reg];
    headBad = headDone && (robExc_reg[head_reg] || robMisp_reg[head_reg]);
    retRen = robRenIdx_reg[head_reg];
  end

  always_comb begin
    robValid_next = robValid_reg;
    robDone_next = robDone_reg;
    robExc_next = robExc_reg;
    robMisp_next = robMisp_reg;
    robSpr_next = robSpr_reg;
    robRen_next = robRen_reg;
    head_next = head_reg;
    tail_next = tail_reg;
    robCount_next = robCount_reg;
    renCount_next = renCount_reg;
    renTail_next = renTail_reg;
    renHead_next = renHead_reg;
    ctrLrPending_next = ctrLrPending_reg;
    lastPage_next = lastPage_reg;
    lastPageValid_next = lastPageValid_reg;
    pc_next = pc_reg;
    wbValid_next = 1'b0;
    wbIdx_next = wbIdx_reg;
    retire_next = 1'b0;
    retTag_next = retTag_reg;
    retSpr_next = 1'b0;
    flush_next = 1'b0;
    redir_next = redir_reg;
    if (fetchEnable) begin
      pc_next = fetchAddr + ADDR_W'(4);
      lastPage_next = fetchAddr[ADDR_W-1:`PAGE_LSB];
      lastPageValid_next = 1'b1;
    end
    if (finValid && robValid_reg[finTag]) begin
      robDone_next[finTag] = 1'b1;
      robExc_next[finTag] = finExcept;
      robMisp_next[finTag] = finMispredict;
    end
    if (doDisp) begin
      robValid_next[tail_reg] = 1'b1;
      robDone_next[tail_reg] = 1'b0;
      robExc_next[tail_reg] = 1'b0;
      robMisp_next[tail_reg] = 1'b0;
      robSpr_next[tail_reg] = dispWritesCtrLr || dispWritesCond;
      robRen_next[tail_reg] = dispNeedsRename;
      tail_next = tail_reg + 1'b1;
      robCount_next = robCount_next + 1'b1;
      if (dispNeedsRename) begin
        renTail_next = renTail_reg + 1'b1;
        renCount_next = renCount_next + 1'b1;
      end
      if (dispWritesCtrLr)
        ctrLrPending_next = 1'b1;
    end
    if (headDone) begin
      retire_next = 1'b1;
      retTag_next = head_reg;
      retSpr_next = robSpr_reg[head_reg];
      if (robSpr_reg[head_reg])
        ctrLrPending_next = 1'b0;
      if (robRen_reg[head_reg]) begin
        wbValid_next = 1'b1;
        wbIdx_next = retRen;
        renHead_next = renHead_reg + 1'b1;
        renCount_next = renCount_next - 1'b1;
      end
      robValid_next[head_reg] = 1'b0;
      head_next = head_reg + 1'b1;
      robCount_next = robCount_next - 1'b1;
    end
    if (headBad) begin
      flush_next = 1'b1;
      redir_next = robTgt_reg[head_reg];
      robValid_next = '0;
      tail_next = head_reg + 1'b1;
      robCount_next = '0;
      renTail_next = renHead_next;
      renCount_next = '0;
      ctrLrPending_next = 1'b0;
    end
  end

  always_comb begin
    // multicycle integer unit
    mcState_next = mcState_reg;
    mcCnt_next = mcCnt_reg;
    mulPipe_next = {mulPipe_reg[`MUL_STAGES-2:0], 1'b0};
    if (doDisp && dispUnit == UNIT_MCI && (dispIsMul || dispIsDiv))
      mulPipe_next[0] = 1'b1;
    case (mcState_reg)
      MC_IDLE: begin
        if (doDisp && dispUnit == UNIT_MCI && dispIsDiv) begin
          mcState_next = MC_RUN;
          mcCnt_next = `DIV_ITER_CYCLES;
        end
      end
      MC_RUN: mcState_next = MC_ITER; // reaches stage two
      MC_ITER: begin
        mcCnt_next = mcCnt_reg - 8'h01;
        if (mcCnt_reg == 8'h01)
          mcState_next = MC_IDLE;
      end
      default: mcState_next = MC_IDLE;
    endcase
    fpPipe_next = {fpPipe_reg[`FP_STAGES-2:0], 1'b0};
    fpCnt_next = fpCnt_reg;
    if (fpCnt_reg != 8'h00) begin
      fpCnt_next = fpCnt_reg - 8'h01;
      fpPipe_next[0] = 1'b0;
      if (fpCnt_reg == 8'h01)
        fpPipe_next[0] = 1'b1;
    end else if (doDisp && dispIsFp) begin
      fpPipe_next[0] = !dispIsFpDiv;
      if (dispIsFpDiv)
        fpCnt_next = `FPDIV_ITER_CYCLES;
    end
    stage_next = {wbValid_reg, headDone, finValid, doDisp, dispValid, fetchEnable};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      robValid_reg <= '0;
      robDone_reg <= '0;
      robExc_reg <= '0;
      robMisp_reg <= '0;
      robSpr_reg <= '0;
      robRen_reg <= '0;
      head_reg <= '0;
      tail_reg <= '0;
      robCount_reg <= '0;
      renCount_reg <= '0;
      renTail_reg <= '0;
      renHead_reg <= '0;
      ctrLrPending_reg <= 1'b0;
      lastPage_reg <= '0;
      lastPageValid_reg <= 1'b0;
      pc_reg <= '0;
      wbValid_reg <= 1'b0;
      wbIdx_reg <= '0;
      retire_reg <= 1'b0;
      retTag_reg <= '0;
      retSpr_reg <= 1'b0;
      flush_reg <= 1'b0;
      redir_reg <= '0;
      mcState_reg <= MC_IDLE;
      mcCnt_reg <= 8'h00;
      mulPipe_reg <= '0;
      fpCnt_reg <= 8'h00;
      fpPipe_reg <= '0;
      stage_reg <= '0;
    end else begin
      robValid_reg <= robValid_next;
      robDone_reg <= robDone_next;
      robExc_reg <= robExc_next;
      robMisp_reg <= robMisp_next;
      robSpr_reg <= robSpr_next;
      robRen_reg <= robRen_next;
      head_reg <= head_next;
      tail_reg <= tail_next;
      robCount_reg <= robCount_next;
      renCount_reg <= renCount_next;
      renTail_reg <= renTail_next;
      renHead_reg <= renHead_next;
      ctrLrPending_reg <= ctrLrPending_next;
      lastPage_reg <= lastPage_next;
      lastPageValid_reg <= lastPageValid_next;
      pc_reg <= pc_next;
      wbValid_reg <= wbValid_next;
      wbIdx_reg <= wbIdx_next;
      retire_reg <= retire_next;
      retTag_reg <= retTag_next;
      retSpr_reg <= retSpr_next;
      flush_reg <= flush_next;
      redir_reg <= redir_next;
      mcState_reg <= mcState_next;
      mcCnt_reg <= mcCnt_next;
      mulPipe_reg <= mulPipe_next;
      fpCnt_reg <= fpCnt_next;
      fpPipe_reg <= fpPipe_next;
      stage_reg <= stage_next;
    end
  end

  // per-entry payload, no reset needed
  always_ff @(posedge clk_sys) begin
    if (doDisp)
      robRenIdx_reg[tail_reg] <= renTail_reg;
    if (finValid)
      robTgt_reg[finTag] <= finTarget;
  end

  assign retireValid = retire_reg;
  assign retireTag = retTag_reg;
  assign retireSprUpdate = retSpr_reg;
  assign writebackValid = wbValid_reg;
  assign writebackRenameIdx = wbIdx_reg;
  assign flush = flush_reg;
  assign redirectAddr = redir_reg;
  assign mulBusy = (mcState_reg != MC_IDLE) || (mulPipe_reg != '0);
  assign fpIterBusy = fpCnt_reg != 8'h00;
  assign stageActive = stage_reg;
endmodule

// ===== sim/superscalar_pipeline_control_checker.sv
/*
  port-level assertions for the pipeline control block.
  assumes it is bound onto the top module of the design.
*/
module superscalar_pipeline_control_checker
  import pipe_ctrl_pkg::*;
#(
  parameter int RS_DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic decodeQueueFull,
  input wire logic dispValid,
  input wire logic [2:0] dispUnit,
  input wire logic dispIsDiv,
  input wire logic decodeBranchViaCtrLr,
  input wire logic [1:0] decodeSlot,
  input wire logic [RS_DEPTH:0] crlRsFree,
  input wire logic [RS_DEPTH:0] brRsFree,
  input wire logic fetchEnable,
  input wire logic decodeCorrect,
  input wire logic dispAccept,
  input wire logic [3:0] dispTag,
  input wire logic retireValid,
  input wire logic [3:0] retireTag,
  input wire logic flush,
  input wire logic mulBusy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_flush_retires: assert property (flush |-> retireValid)
    else $error("flush without retirement of the faulting entry");
  chk_flush_stalls: assert property (flush |-> !dispAccept)
    else $error("dispatch accepted during flush");
  chk_rs_full_block: assert property (
    dispValid && dispUnit inside {UNIT_BR, UNIT_CRL} && (crlRsFree == '0 || brRsFree == '0)
    |-> !dispAccept) else $error("branch or logic dispatch with a full station");
  chk_decode_slot: assert property (
    decodeCorrect |-> decodeBranchViaCtrLr && decodeSlot < 2'h2)
    else $error("decode correction outside first two slots");
  chk_fetch_stall: assert property (decodeQueueFull |-> !fetchEnable)
    else $error("fetch while decode queue full");
  chk_retire_order: assert property (
    retireValid && $past(retireValid) |-> retireTag == $past(retireTag) + 4'h1)
    else $error("retirement out of order");
  chk_div_busy: assert property (
    dispAccept && dispIsDiv && dispUnit == UNIT_MCI |-> ##2 mulBusy [*8])
    else $error("divide not iterating");
  chk_tag_seq: assert property (dispAccept ##1 dispAccept |->
    dispTag == $past(dispTag) + 4'h1) else $error("reorder tags not allocated in sequence");

  cover property (flush);
  cover property (retireValid ##1 retireValid);
  cover property (dispValid && !dispAccept);
endmodule

bind superscalar_pipeline_control superscalar_pipeline_control_checker #(.RS_DEPTH(RS_DEPTH))
  chk_i (.clk_sys, .rst_n, .decodeQueueFull, .dispValid, .dispUnit, .dispIsDiv,
  .decodeBranchViaCtrLr, .decodeSlot, .crlRsFree, .brRsFree, .fetchEnable, .decodeCorrect,
  .dispAccept, .dispTag, .retireValid, .retireTag, .flush, .mulBusy);

// ===== sim/superscalar_pipeline_control_tb_top.sv
/*
  self-checking bench for the pipeline control block.
  assumes the package, design and checker are compiled first.
*/
module superscalar_pipeline_control_tb_top
  import pipe_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, rst_n = 1'b0;
  logic instrTranslateEnable = 1'b1, icacheHit = 1'b0, decodeQueueFull = 1'b0;
  logic dispValid = 1'b0, dispNeedsRename = 1'b0, dispIsMul = 1'b0, dispIsDiv = 1'b0;
  logic dispIsSpr = 1'b0, dispIsFpDiv = 1'b0, dispIsFp = 1'b0, dispWritesCtrLr = 1'b0;
  logic dispWritesCond = 1'b0, decodeBranchViaCtrLr = 1'b0, finValid = 1'b0;
  logic finExcept = 1'b0, finMispredict = 1'b0;
  logic [2:0] dispUnit = 3'h0, crlRsFree = 3'h2, brRsFree = 3'h2;
  logic [1:0] decodeSlot = 2'h0;
  logic [3:0] finTag = 4'h0;
  logic [31:0] fetchAddr = 32'h0, finTarget = 32'h0;
  logic fetchEnable, decodeCorrect, dispAccept, retireValid, retireSprUpdate;
  logic writebackValid, flush, mulBusy, fpIterBusy;
  logic [31:0] nextFetchAddr, redirectAddr;
  logic [3:0] dispTag, dispRenameIdx, retireTag, writebackRenameIdx;
  logic [5:0] stageActive;
  int badCount = 0, nChecks = 0;

  superscalar_pipeline_control dut (.clk_sys, .rst_n, .instrTranslateEnable, .icacheHit,
    .fetchAddr, .decodeQueueFull, .dispValid, .dispUnit, .dispNeedsRename, .dispIsMul,
    .dispIsDiv, .dispIsSpr, .dispIsFpDiv, .dispIsFp, .dispWritesCtrLr, .dispWritesCond,
    .decodeBranchViaCtrLr, .decodeSlot, .crlRsFree, .brRsFree, .finValid, .finTag,
    .finExcept, .finMispredict, .finTarget, .fetchEnable, .nextFetchAddr, .decodeCorrect,
    .dispAccept, .dispTag, .dispRenameIdx, .retireValid, .retireTag, .retireSprUpdate,
    .writebackValid, .writebackRenameIdx, .flush, .redirectAddr, .mulBusy, .fpIterBusy,
    .stageActive);

  always #2.5 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (badCount == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic testFetch();
    @(posedge clk_sys);
    decodeQueueFull <= 1'b1;
    #1 chk(fetchEnable, 1'b0);
    @(posedge clk_sys);
    {decodeQueueFull, instrTranslateEnable, icacheHit} <= 3'h1;
    fetchAddr <= 32'h0000_1000;
    #1 chk(fetchEnable, 1'b1);
    @(posedge clk_sys);
    icacheHit <= 1'b0;
    fetchAddr <= 32'h0000_1ff0;
    #1 chk(fetchEnable, 1'b1);
    @(posedge clk_sys);
    fetchAddr <= 32'h0000_2000;
    #1 chk(fetchEnable, 1'b0);
    @(posedge clk_sys);
    instrTranslateEnable <= 1'b1;
    #1 chk(fetchEnable, 1'b1);
  endtask

  task automatic testDecode();
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      decodeBranchViaCtrLr <= 1'b1;
      decodeSlot <= 2'(s);
      #1 chk(decodeCorrect, s < 2);
    end
  endtask

  task automatic testRetire();
    @(posedge clk_sys);
    {dispValid, dispNeedsRename, dispWritesCond} <= 3'h7;
    #1 chk(dispTag, 4'h0);
    chk(dispRenameIdx, 4'h0);
    @(posedge clk_sys);
    dispWritesCond <= 1'b0;
    #1 chk(dispTag, 4'h1);
    chk(dispRenameIdx, 4'h1);
    @(posedge clk_sys);
    {dispValid, dispNeedsRename, finValid} <= 3'h1;
    finTag <= 4'h1;
    @(posedge clk_sys);
    finTag <= 4'h0;
    #1 chk(retireValid, 1'b0);
    @(posedge clk_sys);
    finValid <= 1'b0;
    @(posedge clk_sys);
    #1 chk({retireValid, retireTag, writebackValid}, 6'h21);
    chk(retireSprUpdate, 1'b1);
    @(posedge clk_sys);
    #1 chk({retireValid, retireTag}, 5'h11);
    chk(retireSprUpdate, 1'b0);
    chk(writebackRenameIdx, 4'h1);
  endtask

  task automatic testFlush();
    logic [3:0] t;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      dispValid <= 1'b1;
      #1 t = dispTag;
      @(posedge clk_sys);
      @(posedge clk_sys);
      {dispValid, finValid, finExcept, finMispredict} <= {2'h1, k == 0, k == 1};
      finTag <= t;
      finTarget <= 32'h0000_8000 + 32'(k);
      @(posedge clk_sys);
      finValid <= 1'b0;
      @(posedge clk_sys);
      dispValid <= 1'b1;
      #1 chk({flush, retireValid, retireTag, dispAccept}, {2'h3, t, 1'b0});
      chk(redirectAddr, 32'h0000_8000 + 32'(k));
      chk(nextFetchAddr, 32'h0000_8000 + 32'(k));
      @(posedge clk_sys);
      {dispValid, finValid} <= 2'h1;
      finTag <= t + 4'h1;
      @(posedge clk_sys);
      finValid <= 1'b0;
      @(posedge clk_sys);
      #1 chk(retireValid, 1'b0);
    end
  endtask

  task automatic testIter();
    int n;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      dispValid <= 1'b1;
      dispUnit <= k ? UNIT_FP : UNIT_MCI;
      {dispIsDiv, dispIsFpDiv, dispIsFp} <= {k == 0, k == 1, k == 1};
      #1 chk(dispAccept, 1'b1);
      @(posedge clk_sys);
      {dispIsDiv, dispIsFpDiv, dispIsFp, dispIsSpr} <= 4'h1;
      dispUnit <= UNIT_MCI;
      #1 chk(dispAccept, 1'b1);
      @(posedge clk_sys);
      {dispIsSpr, dispIsMul, dispIsFp} <= {1'b0, k == 0, k == 1};
      dispUnit <= k ? UNIT_FP : UNIT_MCI;
      #1 chk({dispAccept, k ? fpIterBusy : mulBusy}, 2'h1);
      for (n = 0; n < 40 && dispAccept !== 1'b1; n++) @(posedge clk_sys) #1;
      if (n == 40) begin
        chk(1'b0, 1'b1);
        results();
      end
      chk(n > 8, 1'b1);
      @(posedge clk_sys);
      {dispValid, dispIsMul, dispIsFp} <= 3'h0;
    end
  endtask

  task automatic testRs();
    for (int u = 4; u < 6; u++) begin
      for (int f = 0; f < 2; f++) begin
        @(posedge clk_sys);
        dispValid <= 1'b1;
        dispUnit <= 3'(u);
        crlRsFree <= f ? 3'h2 : 3'h0;
        brRsFree <= f ? 3'h0 : 3'h2;
        #1 chk(dispAccept, 1'b0);
      end
    end
    @(posedge clk_sys);
    {crlRsFree, brRsFree} <= 6'h12;
    dispUnit <= UNIT_BR;
    dispWritesCtrLr <= 1'b1;
    #1 chk(dispAccept, 1'b1);
    @(posedge clk_sys);
    {dispValid, dispWritesCtrLr} <= 2'h0;
    decodeSlot <= 2'h0;
    #1 chk(decodeCorrect, 1'b0);
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk({retireValid, flush, stageActive}, 8'h0);
    testFetch();
    testDecode();
    testRetire();
    testFlush();
    testIter();
    testRs();
    results();
  end
endmodule
